// >>> core/ahp_host_port.sv
// host bus port: strobe decoding, data bus drive, interrupt pin and clock-mode strap
`timescale 1ns/1ps
`default_nettype none

module ahp_host_port (
   // clock and reset
   input  wire  logic                        core_clk,
   input  wire  logic                        sys_rst,
   // host bus
   input  wire  logic                        cs_n,
   input  wire  logic                        rd_n,
   input  wire  logic                        wr_n,
   input  wire  logic [ahp_pkg::IDX_W-1:0]   register_index,
   input  wire  logic [ahp_pkg::REG_W-1:0]   host_data_bus_in,
   output logic       [ahp_pkg::REG_W-1:0]   host_data_bus_out,
   output logic                              host_data_bus_oe_n,
   output logic                              int_req,
   // request to send pin, input during reset
   input  wire  logic                        rts_in,
   output logic                              rts_out,
   output logic                              rts_oe_n,
   // clock source pins
   input  wire  logic                        crystal_output,
   output logic                              gpo_or_crystal_out,
   output logic                              clk_is_crystal,
   // core side
   input  wire  logic [ahp_pkg::NUM_EVT-1:0] unit_event,
   output var   ahp_pkg::ahp_wr_s            cfg_wr,
   output logic       [ahp_pkg::REG_W-1:0]   ctrl
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   ahp_pkg::ahp_state_e              state;       // access machine
   ahp_pkg::ahp_state_e              next_state;  // its next value
   ahp_pkg::ahp_wr_s                 wr_hold;     // byte and index caught while strobe low
   logic [ahp_pkg::REG_W-1:0]        rd_value;    // selected byte, combinational
   logic [ahp_pkg::REG_W-1:0]        status;      // live status byte
   logic [ahp_pkg::BANK_W-1:0]       bank;        // current bank
   logic                             rd_act;      // read strobe qualified by select
   logic                             wr_act;      // write strobe qualified by select
   logic                             wr_end;      // write strobe window closes
   logic                             ev_any;      // some source pending

   assign rd_act = !cs_n && !rd_n;
   assign wr_act = !cs_n && !wr_n;
   assign wr_end = (state == ahp_pkg::AHP_WRITE) && !wr_act;
   assign ev_any = |unit_event;

   // ----------------------------------------------------------------
   // access machine: one access per strobe window.  the strobes are
   // taken as levels, so a strobe of any length that spans at least one
   // system clock edge yields exactly one access; both strobes low is ignored
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      case (state)
         ahp_pkg::AHP_IDLE: begin
            if (rd_act && !wr_act) begin
               next_state = ahp_pkg::AHP_READ;
            end else if (wr_act && !rd_act) begin
               next_state = ahp_pkg::AHP_WRITE;
            end
         end
         ahp_pkg::AHP_READ: begin
            if (!rd_act) begin
               next_state = ahp_pkg::AHP_IDLE;
            end
         end
         ahp_pkg::AHP_WRITE: begin
            if (!wr_act) begin
               next_state = ahp_pkg::AHP_IDLE;
            end
         end
         default: begin
            next_state = ahp_pkg::AHP_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state <= ahp_pkg::AHP_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // write capture: keep the last byte seen while the strobe is low,
   // so data that settles late in the strobe is the one stored
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         wr_hold <= '0;
      end else if (wr_act) begin
         wr_hold.index <= register_index;
         wr_hold.data  <= host_data_bus_in;
      end
   end

   // commit pulse, one cycle after the strobe window closes
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         cfg_wr <= '0;
      end else begin
         cfg_wr.valid <= wr_end;
         cfg_wr.index <= wr_hold.index;
         cfg_wr.data  <= wr_hold.data;
      end
   end

   // ----------------------------------------------------------------
   // register file
   // ----------------------------------------------------------------
   ahp_reg_file u_regs (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .wr       (cfg_wr),
      .rd_index (register_index),
      .status   (status),
      .rd_value (rd_value),
      .bank     (bank),
      .ctrl     (ctrl)
   );

   // live status byte
   always_comb begin
      status                     = '0;
      status[ahp_pkg::ST_CRYSTAL] = clk_is_crystal;
      status[ahp_pkg::ST_EVENT]   = ev_any;
      status[ahp_pkg::ST_INT]     = int_req;
   end

   // ----------------------------------------------------------------
   // read path: data from a flop, so the byte is valid from the
   // second cycle of the strobe; a host that samples earlier sees the
   // undriven bus
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         host_data_bus_out <= '0;
      end else begin
         host_data_bus_out <= rd_value;
      end
   end

   // bus drive only inside a read window with select low
   assign host_data_bus_oe_n = !((state == ahp_pkg::AHP_READ) && rd_act);

   // ----------------------------------------------------------------
   // interrupt pin: level, held while a source is pending and enabled
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         int_req <= 1'b0;
      end else begin
         int_req <= ctrl[ahp_pkg::CTRL_INT_EN] && ev_any;
      end
   end

   // ----------------------------------------------------------------
   // clock-mode strap: caught by a clocked process while reset is high,
   // frozen afterwards so no register write can switch the shared pin's mode
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         clk_is_crystal <= (rts_in == ahp_pkg::STRAP_CRYSTAL);
      end
   end

   // request to send pin: input during reset, driven afterwards
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rts_oe_n <= 1'b1;
         rts_out  <= 1'b1;
      end else begin
         rts_oe_n <= 1'b0;
         rts_out  <= ctrl[ahp_pkg::CTRL_RTS_N];
      end
   end

   // shared pin: oscillator in crystal mode, host output otherwise
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         gpo_or_crystal_out <= 1'b1;
      end else if (clk_is_crystal) begin
         gpo_or_crystal_out <= crystal_output;
      end else begin
         gpo_or_crystal_out <= ctrl[ahp_pkg::CTRL_GPO_N];
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   // assertions stay quiet while reset is held; the reset checks look at
   // the first edge after release, where $fell sees the falling level and
   // $past still returns the last value loaded by reset
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   // access state, bus enable, interrupt pin and control byte back at their wake-up values on release
   chk_reset_idle: assert property ($fell(sys_rst) |-> state == ahp_pkg::AHP_IDLE
      && host_data_bus_oe_n && !int_req && ctrl == ahp_pkg::CTRL_RST)
      else $error("state not at defaults after reset");

   // a deselected port drives nothing and ends any access
   chk_select_gate: assert property (cs_n |-> host_data_bus_oe_n ##1
      state == ahp_pkg::AHP_IDLE)
      else $error("bus driven or access kept with select high");

   // read data is the flop loaded from the selected byte
   chk_read_drive: assert property ((state == ahp_pkg::AHP_READ && rd_act)
      |-> !host_data_bus_oe_n && host_data_bus_out == $past(rd_value))
      else $error("read window without data on the bus");

   // the bus is released in every state but a read
   chk_no_idle_drive: assert property (state != ahp_pkg::AHP_READ
      |-> host_data_bus_oe_n)
      else $error("bus driven outside a read");

   // a closing write window gives exactly one commit pulse
   chk_write_commit: assert property (wr_end |=> cfg_wr.valid
      && cfg_wr.data == $past(wr_hold.data) ##1 !cfg_wr.valid)
      else $error("write window closed without one commit");

   // commit pulses land only once the machine is idle again
   chk_commit_idle: assert property (cfg_wr.valid |-> state == ahp_pkg::AHP_IDLE)
      else $error("commit pulse while a strobe is still low");

   // both strobes low together is refused
   chk_both_low: assert property ((state == ahp_pkg::AHP_IDLE && rd_act && wr_act)
      |=> state == ahp_pkg::AHP_IDLE)
      else $error("access taken with both strobes low");

   // a legal bank number is applied on the commit edge
   chk_bank_switch: assert property ((cfg_wr.valid && cfg_wr.index == ahp_pkg::BANK_IDX
      && cfg_wr.data < ahp_pkg::REG_W'(ahp_pkg::NUM_BANKS))
      |=> bank == $past(cfg_wr.data[ahp_pkg::BANK_W-1:0]))
      else $error("bank select write not applied");

   // the bank never points past the last implemented register
   chk_bank_range: assert property (bank < ahp_pkg::BANK_W'(ahp_pkg::NUM_BANKS))
      else $error("bank select out of range");

   // an enabled pending source raises the pin one cycle later
   chk_int_level: assert property ((ctrl[ahp_pkg::CTRL_INT_EN] && ev_any)[*2]
      |-> int_req)
      else $error("enabled source did not raise interrupt");

   // a disabled interrupt keeps the pin low
   chk_int_quiet: assert property ((!ctrl[ahp_pkg::CTRL_INT_EN])[*2] |-> !int_req)
      else $error("interrupt raised while disabled");

   // the clock mode never moves outside reset
   chk_mode_hold: assert property (!$past(sys_rst) |-> $stable(clk_is_crystal))
      else $error("clock mode moved outside reset");

   // the strap is the request to send level of the last reset edge
   chk_strap_take: assert property ($fell(sys_rst) |-> rts_oe_n
      && clk_is_crystal == ($past(rts_in) == ahp_pkg::STRAP_CRYSTAL) ##1 !rts_oe_n)
      else $error("strap not taken from request to send");

   // once out of reset the request to send pin is an output
   chk_rts_drive: assert property (!$past(sys_rst)
      |-> !rts_oe_n && rts_out == $past(ctrl[ahp_pkg::CTRL_RTS_N]))
      else $error("request to send pin not driven from control");

   // external mode: the shared pin follows the control bit
   chk_gpo_mux: assert property ((!clk_is_crystal && $past(!sys_rst))
      |-> gpo_or_crystal_out == $past(ctrl[ahp_pkg::CTRL_GPO_N]))
      else $error("shared pin not following host output");

   // crystal mode: the shared pin follows the oscillator cell
   chk_xtal_pass: assert property ((clk_is_crystal && $past(!sys_rst))
      |-> gpo_or_crystal_out == $past(crystal_output))
      else $error("shared pin not following the oscillator");

   // main scenarios
   cov_read: cover property (rd_act ##1 state == ahp_pkg::AHP_READ ##1 !rd_act);
   cov_write: cover property (wr_end ##1 cfg_wr.valid);
   cov_bank: cover property (cfg_wr.valid && cfg_wr.index == ahp_pkg::BANK_IDX);
   cov_int: cover property ($rose(int_req));
   cov_both_low: cover property (state == ahp_pkg::AHP_IDLE && rd_act && wr_act);

endmodule

`default_nettype wire

// >>> core/ahp_pkg.sv
// constants, types and helpers shared by the host bus port and its register file
`default_nettype none
package ahp_pkg;

   // ----------------------------------------------------------------
   // bus widths
   // ----------------------------------------------------------------
   localparam int unsigned REG_W     = 8;   // host data bus width
   localparam int unsigned IDX_W     = 3;   // host register index width
   localparam int unsigned BANK_W    = 3;   // bank select field width
   localparam int unsigned FLAT_W    = 6;   // flat register number width
   localparam int unsigned NUM_BANKS = 5;   // banks reachable through the window
   localparam int unsigned SLOTS     = 7;   // banked slots per bank
   localparam int unsigned NUM_REGS  = 35;  // banked registers in total
   localparam int unsigned NUM_EVT   = 4;   // internal interrupt sources

   // ----------------------------------------------------------------
   // address map
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0]  BANK_IDX    = 3'h2;   // bank select, seen in every bank
   localparam logic [FLAT_W-1:0] CTRL_FLAT   = 6'h00;  // bank 0, index 0
   localparam logic [FLAT_W-1:0] STATUS_FLAT = 6'h01;  // bank 0, index 1, read only

   // ----------------------------------------------------------------
   // field positions and reset values
   // ----------------------------------------------------------------
   localparam int unsigned CTRL_GPO_N  = 0;  // general purpose output level
   localparam int unsigned CTRL_RTS_N  = 1;  // request to send level
   localparam int unsigned CTRL_INT_EN = 2;  // interrupt output enable
   localparam logic [REG_W-1:0] CTRL_RST = 8'h03;  // outputs idle high, int off
   localparam logic [REG_W-1:0] REG_RST  = 8'h00;
   localparam logic [BANK_W-1:0] BANK_RST = 3'h0;
   localparam int unsigned ST_CRYSTAL = 0;  // status: crystal clock mode
   localparam int unsigned ST_EVENT   = 1;  // status: any source pending
   localparam int unsigned ST_INT     = 2;  // status: interrupt pin level
   localparam logic STRAP_CRYSTAL = 1'b0;  // request to send level that picks crystal

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      AHP_IDLE  = 2'b00,
      AHP_READ  = 2'b01,
      AHP_WRITE = 2'b10
   } ahp_state_e;

   typedef struct packed {
      logic             valid;  // one-cycle commit pulse
      logic [IDX_W-1:0] index;  // register index of the access
      logic [REG_W-1:0] data;   // byte written
   } ahp_wr_s;

   // ----------------------------------------------------------------
   // flat register number from bank and window index
   // ----------------------------------------------------------------
   function automatic logic [FLAT_W-1:0] ahp_flat(input logic [BANK_W-1:0] bank,
                                                  input logic [IDX_W-1:0]  idx);
      logic [FLAT_W-1:0] slot;
      slot = (idx < BANK_IDX) ? FLAT_W'(idx) : FLAT_W'(idx) - FLAT_W'(1);
      return FLAT_W'(bank) * FLAT_W'(SLOTS) + slot;
   endfunction

endpackage

`default_nettype wire

// >>> core/ahp_reg_file.sv
// banked register store behind the three-bit host window
`timescale 1ns/1ps
`default_nettype none

module ahp_reg_file (
   // clock and reset
   input  wire  logic                       core_clk,
   input  wire  logic                       sys_rst,
   // committed write
   input  wire  ahp_pkg::ahp_wr_s           wr,
   // read side
   input  wire  logic [ahp_pkg::IDX_W-1:0]  rd_index,
   input  wire  logic [ahp_pkg::REG_W-1:0]  status,
   output logic       [ahp_pkg::REG_W-1:0]  rd_value,
   // register contents
   output logic       [ahp_pkg::BANK_W-1:0] bank,
   output logic       [ahp_pkg::REG_W-1:0]  ctrl
);

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   logic [ahp_pkg::REG_W-1:0]  mem [ahp_pkg::NUM_REGS];  // banked registers
   logic [ahp_pkg::FLAT_W-1:0] wr_flat;                  // flat target of a write
   logic [ahp_pkg::FLAT_W-1:0] rd_flat;                  // flat target of a read
   logic                       wr_bank;                  // write hits bank select

   assign wr_flat = ahp_pkg::ahp_flat(bank, wr.index);
   assign rd_flat = ahp_pkg::ahp_flat(bank, rd_index);
   assign wr_bank = (wr.index == ahp_pkg::BANK_IDX);
   assign ctrl    = mem[ahp_pkg::CTRL_FLAT];

   // ----------------------------------------------------------------
   // bank select: out-of-range values are dropped so the window never
   // points past the last register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         bank <= ahp_pkg::BANK_RST;
      end else if (wr.valid && wr_bank &&
                   wr.data < ahp_pkg::REG_W'(ahp_pkg::NUM_BANKS)) begin
         bank <= wr.data[ahp_pkg::BANK_W-1:0];
      end
   end

   // ----------------------------------------------------------------
   // banked registers; the status slot ignores writes
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < ahp_pkg::NUM_REGS; i++) begin
            mem[i] <= ahp_pkg::REG_RST;
         end
         mem[ahp_pkg::CTRL_FLAT] <= ahp_pkg::CTRL_RST;
      end else if (wr.valid && !wr_bank && wr_flat != ahp_pkg::STATUS_FLAT) begin
         mem[wr_flat] <= wr.data;
      end
   end

   // ----------------------------------------------------------------
   // read mux: bank select, live status, or stored byte
   // ----------------------------------------------------------------
   always_comb begin
      if (rd_index == ahp_pkg::BANK_IDX) begin
         rd_value = ahp_pkg::REG_W'(bank);
      end else if (rd_flat == ahp_pkg::STATUS_FLAT) begin
         rd_value = status;
      end else begin
         rd_value = mem[rd_flat];
      end
   end

endmodule

`default_nettype wire

// >>> testbench/ahp_host_model.sv
// host processor model: drives the parallel bus and resolves the data wire
`timescale 1ns/1ps
`default_nettype none

module ahp_host_model (
   // clock
   input  wire logic                       core_clk,
   // device side of the data wire
   input  wire logic [ahp_pkg::REG_W-1:0]  dev_out,
   input  wire logic                       dev_oe_n,
   // host strobes and address
   output logic                            cs_n,
   output logic                            rd_n,
   output logic                            wr_n,
   output logic      [ahp_pkg::IDX_W-1:0]  register_index,
   // resolved wire level
   output logic      [ahp_pkg::REG_W-1:0]  bus_level
);
   logic                      host_oe;    // host drives the wire
   logic [ahp_pkg::REG_W-1:0] host_data;  // byte the host drives
   logic [ahp_pkg::REG_W-1:0] last;       // previous wire level

   initial begin
      cs_n = 1'b1;
      rd_n = 1'b1;
      wr_n = 1'b1;
      register_index = 3'h0;
      host_oe = 1'b0;
      host_data = 8'h00;
      last = 8'h00;
   end

   // no pull-up: an undriven wire toggles so stale data never passes
   always_comb begin
      if (!dev_oe_n) begin
         bus_level = dev_out;
      end else if (host_oe) begin
         bus_level = host_data;
      end else begin
         bus_level = ~last;
      end
   end

   always @(posedge core_clk) last <= bus_level;

   // raw strobe levels, used for refused accesses
   task automatic raw(input logic c, input logic r, input logic w,
                      input logic [ahp_pkg::IDX_W-1:0] idx);
      @(posedge core_clk);
      #1;
      cs_n = c;
      rd_n = r;
      wr_n = w;
      register_index = idx;
   endtask

   // write: select, index and data held for the whole strobe
   task automatic bus_write(input logic [ahp_pkg::IDX_W-1:0] idx,
                            input logic [ahp_pkg::REG_W-1:0] data);
      raw(1'b0, 1'b1, 1'b0, idx);
      host_data = data;
      host_oe = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      cs_n = 1'b1;
      wr_n = 1'b1;
      host_oe = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   // read: hold the strobe until the device is seen driving
   task automatic bus_read(input logic [ahp_pkg::IDX_W-1:0] idx,
                           output logic [ahp_pkg::REG_W-1:0] data);
      int n;
      raw(1'b0, 1'b0, 1'b1, idx);
      data = 8'hxx;
      for (n = 0; n < 8; n++) begin
         @(posedge core_clk);
         #1;
         if (!dev_oe_n) break;
      end
      if (!dev_oe_n) data = bus_level;
      cs_n = 1'b1;
      rd_n = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
   endtask
endmodule
`default_nettype wire

// >>> testbench/tb_ahp_host_port.sv
// self-checking bench for the host bus port
`timescale 1ns/1ps
`default_nettype none

module tb_ahp_host_port;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic                    core_clk = 1'b0;
   logic                    sys_rst  = 1'b1;
   logic                    cs_n, rd_n, wr_n;
   logic [2:0]              register_index;
   logic [7:0]              bus_level, dout;
   logic                    oe_n, int_req, rts_out, rts_oe_n;
   logic                    rts_in   = 1'b0;
   logic                    xtal     = 1'b0;
   logic                    gpo_pin, crystal;
   logic [3:0]              unit_event = 4'h0;
   ahp_pkg::ahp_wr_s        cfg_wr, wr_seen;
   logic [7:0]              ctrl, rd;
   int                      fails = 0, tests_run = 0, wr_cnt = 0, cyc = 0;

   always #10 core_clk = ~core_clk;

   ahp_host_model host_u (.core_clk(core_clk), .dev_out(dout), .dev_oe_n(oe_n),
      .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n), .register_index(register_index),
      .bus_level(bus_level));

   ahp_host_port dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .cs_n(cs_n),
      .rd_n(rd_n), .wr_n(wr_n), .register_index(register_index),
      .host_data_bus_in(bus_level), .host_data_bus_out(dout),
      .host_data_bus_oe_n(oe_n), .int_req(int_req), .rts_in(rts_in),
      .rts_out(rts_out), .rts_oe_n(rts_oe_n), .crystal_output(xtal),
      .gpo_or_crystal_out(gpo_pin), .clk_is_crystal(crystal),
      .unit_event(unit_event), .cfg_wr(cfg_wr), .ctrl(ctrl));

   // keeps the last committed write and counts them
   always @(posedge core_clk) begin
      if (cfg_wr.valid === 1'b1) begin
         wr_seen <= cfg_wr;
         wr_cnt  <= wr_cnt + 1;
      end
   end

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   // strap level is sampled while reset is held
   task automatic do_reset(input logic strap);
      @(posedge core_clk);
      #1;
      sys_rst = 1'b1;
      rts_in  = strap;
      repeat (12) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
   endtask

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic test_crystal();
      check("mode", 8'(crystal), 8'h01);
      check("ctrl", ctrl, 8'h03);
      check("int", 8'(int_req), 8'h00);
      check("oe_n", 8'(oe_n), 8'h01);
      check("rts_oe_n", 8'(rts_oe_n), 8'h00);
      xtal = 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      check("xtal hi", 8'(gpo_pin), 8'h01);
      xtal = 1'b0;
      repeat (2) @(posedge core_clk);
      #1;
      check("xtal lo", 8'(gpo_pin), 8'h00);
      $display("test crystal done");
   endtask

   task automatic test_external();
      do_reset(1'b1);
      check("mode", 8'(crystal), 8'h00);
      check("gpo", 8'(gpo_pin), 8'h01);
      rts_in = 1'b0;
      host_u.bus_write(3'h0, 8'h04);
      check("ctrl", ctrl, 8'h04);
      check("wr idx", 8'(wr_seen.index), 8'h00);
      check("wr data", wr_seen.data, 8'h04);
      check("gpo", 8'(gpo_pin), 8'h00);
      check("rts", 8'(rts_out), 8'h00);
      check("mode", 8'(crystal), 8'h00);
      $display("test external done");
   endtask

   task automatic test_interrupt();
      unit_event = 4'h2;
      repeat (2) @(posedge core_clk);
      #1;
      check("int on", 8'(int_req), 8'h01);
      host_u.bus_read(3'h1, rd);
      check("status", rd, 8'h06);
      host_u.bus_write(3'h1, 8'hff);
      host_u.bus_read(3'h1, rd);
      check("status ro", rd, 8'h06);
      host_u.bus_write(3'h0, 8'h01);
      check("int masked", 8'(int_req), 8'h00);
      unit_event = 4'h0;
      $display("test interrupt done");
   endtask

   task automatic test_banks();
      for (int b = 0; b < 5; b++) begin
         host_u.bus_write(3'h2, 8'(b));
         host_u.bus_write(3'h3, 8'h10 + 8'(b));
         host_u.bus_write(3'h7, 8'h80 + 8'(b));
      end
      host_u.bus_write(3'h2, 8'h05);
      host_u.bus_read(3'h2, rd);
      check("bank kept", rd, 8'h04);
      for (int b = 4; b >= 0; b--) begin
         host_u.bus_write(3'h2, 8'(b));
         host_u.bus_read(3'h3, rd);
         check("slot 2", rd, 8'h10 + 8'(b));
         host_u.bus_read(3'h7, rd);
         check("slot 6", rd, 8'h80 + 8'(b));
      end
      $display("test banks done");
   endtask

   task automatic test_deselect();
      int n;
      n = wr_cnt;
      host_u.raw(1'b1, 1'b0, 1'b1, 3'h0);
      repeat (3) @(posedge core_clk);
      #1;
      check("oe_n desel", 8'(oe_n), 8'h01);
      host_u.raw(1'b1, 1'b1, 1'b0, 3'h0);
      host_u.raw(1'b0, 1'b0, 1'b0, 3'h0);
      host_u.raw(1'b1, 1'b1, 1'b1, 3'h0);
      repeat (3) @(posedge core_clk);
      #1;
      check("no commit", 8'(wr_cnt - n), 8'h00);
      check("ctrl kept", ctrl, 8'h01);
      $display("test deselect done");
   endtask

   task automatic test_mid_reset();
      host_u.bus_write(3'h2, 8'h03);
      do_reset(1'b1);
      check("ctrl", ctrl, 8'h03);
      host_u.bus_read(3'h2, rd);
      check("bank", rd, 8'h00);
      $display("test mid reset done");
   endtask

   // hang guard: the whole run needs well under this many cycles
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         fails++;
         finish_test();
      end
   end

   initial begin
      do_reset(1'b0);
      test_crystal();
      test_external();
      test_interrupt();
      test_banks();
      test_deselect();
      test_mid_reset();
      finish_test();
   end
endmodule
`default_nettype wire
